/* File: rtl/cgp_defines.svh */
`ifndef CGP_DEFINES_SVH
`define CGP_DEFINES_SVH

// Register offsets on the serial port address space.
`define CGP_ADDR_PORTCFG 12'h000
`define CGP_ADDR_VARIANT 12'h003
`define CGP_ADDR_RBSEL 12'h004
`define CGP_ADDR_TAGLO 12'h005
`define CGP_ADDR_TAGHI 12'h006
`define CGP_ADDR_PLL 12'h010

// Field positions.
`define CGP_BIT_LSBFIRST 6
`define CGP_BIT_SDOACT 7
`define CGP_BIT_SOFTRST 5
`define CGP_BIT_RBSEL 0
`define CGP_BIT_PDSENSE 7
`define CGP_CP_MSB 6
`define CGP_CP_LSB 4

// Built-in default values.
`define CGP_RST_PORTCFG 8'h00
`define CGP_RST_RBSEL 8'h00
`define CGP_RST_TAG 8'h00
`define CGP_RST_PLL 8'h7D
`define CGP_RST_CP_UA 13'h12C0

// Charge pump current step in microamps.
`define CGP_CP_STEP_UA 13'h258

`endif

/* File: rtl/cgp_pkg.sv */
package cgp_pkg;

    // One register access from the serial port engine.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [11:0] addr;
        logic [7:0] wdata;
    } cgp_req_t;

    // Every writable register, as held in a bank or in the nonvolatile store.
    typedef struct packed {
        logic [7:0] portCfg;
        logic [7:0] rbSel;
        logic [7:0] tagLow;
        logic [7:0] tagHigh;
        logic [7:0] pll;
    } cgp_bank_t;

    // Soft reset sequencing.
    typedef enum logic [1:0] {
        CGP_IDLE,
        CGP_DFLT,
        CGP_NVWAIT
    } cgp_state_t;

endpackage

/* File: rtl/cgp_port_config_regs.sv */
`timescale 1ns/1ps
`include "cgp_defines.svh"
module cgp_port_config_regs
    import cgp_pkg::*;
#(
    // Arbitrary value; it only has to differ between family members.
    parameter logic [7:0] VARIANT_CODE = 8'h5A
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic arst_n,
    // Register access from the serial port engine.
    input wire cgp_req_t req,
    input wire logic ioUpdate,
    input wire logic i2cMode,
    output logic [7:0] rdata,
    output logic rdValid,
    // Nonvolatile store.
    input wire logic nvSelectPin,
    output logic nvLoadReq,
    input wire logic nvLoadDone,
    input wire cgp_bank_t nvLoadData,
    // Controls to the PLL and serial port.
    output logic lsbFirst,
    output logic sdoActive,
    output logic phaseDetectorSense,
    output logic [2:0] chargePumpCurrentCode,
    output logic [12:0] chargePumpCurrentUa,
    output logic softResetBusy
);

    // Built-in defaults for every writable register.
    function automatic cgp_bank_t defaultsBank();
        cgp_bank_t b;
        b.portCfg = `CGP_RST_PORTCFG;
        b.rbSel = `CGP_RST_RBSEL;
        b.tagLow = `CGP_RST_TAG;
        b.tagHigh = `CGP_RST_TAG;
        b.pll = `CGP_RST_PLL;
        return b;
    endfunction

    // Current in microamps for a charge pump code.
    function automatic logic [12:0] cpUa(input logic [2:0] code);
        return (13'({10'h000, code}) + 13'h001) * `CGP_CP_STEP_UA;
    endfunction

    // Readback mux over the address space.
    function automatic logic [7:0] regRead(input logic [11:0] addr, input cgp_bank_t buf_,
                                           input cgp_bank_t act, input logic busy);
        cgp_bank_t sel;
        logic [7:0] v;
        sel = buf_.rbSel[`CGP_BIT_RBSEL] ? act : buf_;
        v = 8'h00;
        case (addr)
            `CGP_ADDR_PORTCFG: begin
                v = buf_.portCfg;
                v[`CGP_BIT_SOFTRST] = busy;
            end
            `CGP_ADDR_VARIANT: v = VARIANT_CODE;
            `CGP_ADDR_RBSEL: v = {7'h00, buf_.rbSel[`CGP_BIT_RBSEL]};
            `CGP_ADDR_TAGLO: v = sel.tagLow;
            `CGP_ADDR_TAGHI: v = sel.tagHigh;
            `CGP_ADDR_PLL: v = sel.pll;
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    // Strap synchroniser; the pin level changes only when stages two and three agree.
    logic nvSyncA_reg, nvSyncB_reg, nvSyncC_reg, nvSel_reg;
    logic nvSel_next;

    always_comb begin
        nvSel_next = nvSel_reg;
        if (nvSyncB_reg == nvSyncC_reg) begin
            nvSel_next = nvSyncB_reg;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            nvSyncA_reg <= 1'b0;
            nvSyncB_reg <= 1'b0;
            nvSyncC_reg <= 1'b0;
            nvSel_reg <= 1'b0;
        end else begin
            nvSyncA_reg <= nvSelectPin;
            nvSyncB_reg <= nvSyncA_reg;
            nvSyncC_reg <= nvSyncB_reg;
            nvSel_reg <= nvSel_next;
        end
    end

    // Register banks, soft reset sequencer and registered outputs.
    cgp_state_t state_reg, state_next;
    cgp_bank_t buf_reg, buf_next, act_reg, act_next;
    logic [7:0] rdata_reg, rdata_next;
    logic rdValid_reg, rdValid_next, nvReq_reg, nvReq_next;
    logic lsb_reg, lsb_next, sdo_reg, sdo_next, pds_reg, pds_next;
    logic [2:0] cp_reg, cp_next;
    logic [12:0] cpUa_reg, cpUa_next;
    logic busy_reg, busy_next;
    logic busy;
    logic softWrite;

    // Busy is registered from the next state, so the port comes straight from a flop.
    assign busy = busy_reg;
    assign softWrite = req.wr && (req.addr == `CGP_ADDR_PORTCFG) && req.wdata[`CGP_BIT_SOFTRST];

    // Writes are dropped while a reload runs, so a reload is never half overwritten.
    always_comb begin
        state_next = state_reg;
        buf_next = buf_reg;
        act_next = act_reg;
        nvReq_next = 1'b0;
        case (state_reg)
            CGP_IDLE: begin
                if (ioUpdate) begin
                    act_next = buf_reg;
                end
                if (req.wr) begin
                    case (req.addr)
                        `CGP_ADDR_PORTCFG: begin
                            buf_next.portCfg = req.wdata;
                            buf_next.portCfg[`CGP_BIT_SOFTRST] = 1'b0;
                            act_next.portCfg = buf_next.portCfg;
                        end
                        `CGP_ADDR_RBSEL: begin
                            buf_next.rbSel = {7'h00, req.wdata[`CGP_BIT_RBSEL]};
                            act_next.rbSel = buf_next.rbSel;
                        end
                        `CGP_ADDR_TAGLO: buf_next.tagLow = req.wdata;
                        `CGP_ADDR_TAGHI: buf_next.tagHigh = req.wdata;
                        `CGP_ADDR_PLL: buf_next.pll = req.wdata;
                        default: buf_next = buf_next;
                    endcase
                end
                if (softWrite) begin
                    if (nvSel_reg) begin
                        state_next = CGP_NVWAIT;
                        nvReq_next = 1'b1;
                    end else begin
                        state_next = CGP_DFLT;
                    end
                end
            end
            CGP_DFLT: begin
                buf_next = defaultsBank();
                act_next = defaultsBank();
                state_next = CGP_IDLE;
            end
            CGP_NVWAIT: begin
                if (nvLoadDone) begin
                    buf_next = nvLoadData;
                    buf_next.portCfg[`CGP_BIT_SOFTRST] = 1'b0;
                    act_next = buf_next;
                    state_next = CGP_IDLE;
                end
            end
            default: state_next = CGP_IDLE;
        endcase
        rdValid_next = req.rd;
        rdata_next = req.rd ? regRead(req.addr, buf_reg, act_reg, busy) : rdata_reg;
        lsb_next = act_next.portCfg[`CGP_BIT_LSBFIRST] && !i2cMode;
        sdo_next = act_next.portCfg[`CGP_BIT_SDOACT] && !i2cMode;
        pds_next = act_next.pll[`CGP_BIT_PDSENSE];
        cp_next = act_next.pll[`CGP_CP_MSB:`CGP_CP_LSB];
        cpUa_next = cpUa(act_next.pll[`CGP_CP_MSB:`CGP_CP_LSB]);
        busy_next = (state_next != CGP_IDLE);
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= CGP_IDLE;
            buf_reg <= {`CGP_RST_PORTCFG, `CGP_RST_RBSEL, `CGP_RST_TAG, `CGP_RST_TAG,
                        `CGP_RST_PLL};
            act_reg <= {`CGP_RST_PORTCFG, `CGP_RST_RBSEL, `CGP_RST_TAG, `CGP_RST_TAG,
                        `CGP_RST_PLL};
            rdata_reg <= 8'h00;
            rdValid_reg <= 1'b0;
            nvReq_reg <= 1'b0;
            lsb_reg <= 1'b0;
            sdo_reg <= 1'b0;
            pds_reg <= 1'(`CGP_RST_PLL >> `CGP_BIT_PDSENSE);
            cp_reg <= 3'(`CGP_RST_PLL >> `CGP_CP_LSB);
            cpUa_reg <= `CGP_RST_CP_UA;
            busy_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            buf_reg <= buf_next;
            act_reg <= act_next;
            rdata_reg <= rdata_next;
            rdValid_reg <= rdValid_next;
            nvReq_reg <= nvReq_next;
            lsb_reg <= lsb_next;
            sdo_reg <= sdo_next;
            pds_reg <= pds_next;
            cp_reg <= cp_next;
            cpUa_reg <= cpUa_next;
            busy_reg <= busy_next;
        end
    end

    // Output ports straight from flip-flops.
    assign rdata = rdata_reg;
    assign rdValid = rdValid_reg;
    assign nvLoadReq = nvReq_reg;
    assign lsbFirst = lsb_reg;
    assign sdoActive = sdo_reg;
    assign phaseDetectorSense = pds_reg;
    assign chargePumpCurrentCode = cp_reg;
    assign chargePumpCurrentUa = cpUa_reg;
    assign softResetBusy = busy;

    // Soft reset with the strap low lands on defaults two edges later.
    softDefault_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        (state_reg == CGP_IDLE && softWrite && !nvSel_reg) |=> ##1
        (buf_reg.pll == `CGP_RST_PLL && act_reg.tagLow == `CGP_RST_TAG))
        else $error("soft reset did not restore defaults");

    // Soft reset with the strap high requests a store load.
    nvRequest_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        (state_reg == CGP_IDLE && softWrite && nvSel_reg) |=> (nvLoadReq && state_reg == CGP_NVWAIT))
        else $error("store load not requested");

    // Store data lands in the active bank.
    nvApply_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        (state_reg == CGP_NVWAIT && nvLoadDone) |=> (act_reg.pll == $past(nvLoadData.pll)))
        else $error("store data not applied");

    // Variant code reads back fixed.
    variantRead_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        (req.rd && req.addr == `CGP_ADDR_VARIANT) |=> (rdValid && rdata == VARIANT_CODE))
        else $error("variant code wrong");

    // Readback bank follows the select bit.
    bankSelect_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        (req.rd && req.addr == `CGP_ADDR_PLL) |=>
        (rdata == ($past(buf_reg.rbSel[0]) ? $past(act_reg.pll) : $past(buf_reg.pll))))
        else $error("readback bank wrong");

    // Tag writes are stored and touch no control output.
    tagStore_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        (state_reg == CGP_IDLE && req.wr && req.addr == `CGP_ADDR_TAGHI && !ioUpdate) |=>
        (buf_reg.tagHigh == $past(req.wdata) && $stable(phaseDetectorSense)))
        else $error("tag write wrong");

    // Sense output tracks the active PLL bit.
    senseTrack_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        phaseDetectorSense == act_reg.pll[7])
        else $error("phase detector sense mismatch");

    // Current is code plus one times the step.
    cpCurrent_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        chargePumpCurrentUa == (13'({10'h000, chargePumpCurrentCode}) + 13'h001) * 13'h258)
        else $error("charge pump current wrong");

    // Bit order control forced off in I2C mode.
    lsbIgnore_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        $past(i2cMode) |-> !lsbFirst)
        else $error("bit order not ignored");

    // Default reload ends in one cycle and the bit reads back low.
    selfClear_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        (state_reg == CGP_DFLT) |=> (!softResetBusy && !buf_reg.portCfg[5]))
        else $error("soft reset bit stuck");

    // A store load request is a single-cycle pulse.
    nvPulse_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        nvLoadReq |=> !nvLoadReq)
        else $error("store load request longer than one cycle");

    // Writes that arrive while the store load runs leave both banks alone.
    reloadGuard_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        (state_reg == CGP_NVWAIT && !nvLoadDone && req.wr) |=>
        ($stable(buf_reg) && $stable(act_reg)))
        else $error("write landed during reload");

    // A write to the variant code changes no register.
    variantWrite_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        (state_reg == CGP_IDLE && req.wr && req.addr == `CGP_ADDR_VARIANT && !ioUpdate) |=>
        ($stable(buf_reg) && $stable(act_reg)))
        else $error("variant write changed a register");

    // Read valid follows each read strobe by exactly one cycle.
    readValid_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        rdValid == $past(req.rd))
        else $error("read valid out of step");

    // Store reload ends with the busy flag and the soft reset bit low.
    nvSelfClear_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        (state_reg == CGP_NVWAIT && nvLoadDone) |=> (!softResetBusy && !buf_reg.portCfg[5]))
        else $error("soft reset bit stuck after store load");

endmodule

/* File: tb/cgp_nv_store_model.sv */
`timescale 1ns/1ps
// Store that answers a load request after a few cycles with a fixed image.
module cgp_nv_store_model
    import cgp_pkg::*;
#(
    parameter int DELAY = 3,
    parameter cgp_bank_t IMAGE = 40'h00_00_A5_5A_25
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic arst_n,
    // Load handshake.
    input wire logic nvLoadReq,
    output logic nvLoadDone,
    output cgp_bank_t nvLoadData
);
    int cnt;
    // Data is only valid with the done pulse; the inverse shows otherwise.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt <= 0;
        end else if (nvLoadReq) begin
            cnt <= DELAY;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end
    end
    assign nvLoadDone = (cnt == 1);
    assign nvLoadData = nvLoadDone ? IMAGE : ~IMAGE;
endmodule

/* File: tb/cgp_port_config_regs_tb.sv */
`timescale 1ns/1ps
module cgp_port_config_regs_tb;
    import cgp_pkg::*;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    cgp_req_t req = '0;
    logic ioUpdate = 1'b0;
    logic i2cMode = 1'b0;
    logic nvSelectPin = 1'b0;
    logic [7:0] rdata;
    logic rdValid, nvLoadReq, nvLoadDone, lsbFirst, sdoActive, phaseDetectorSense;
    logic softResetBusy;
    logic [2:0] chargePumpCurrentCode;
    logic [12:0] chargePumpCurrentUa;
    cgp_bank_t nvLoadData;
    int fail_count = 0;
    int check_count = 0;
    // Variant code value is arbitrary.
    cgp_port_config_regs #(.VARIANT_CODE(8'h5A)) dut (.core_clk(core_clk), .arst_n(arst_n),
        .req(req), .ioUpdate(ioUpdate), .i2cMode(i2cMode), .rdata(rdata), .rdValid(rdValid),
        .nvSelectPin(nvSelectPin), .nvLoadReq(nvLoadReq), .nvLoadDone(nvLoadDone),
        .nvLoadData(nvLoadData), .lsbFirst(lsbFirst), .sdoActive(sdoActive),
        .phaseDetectorSense(phaseDetectorSense), .chargePumpCurrentCode(chargePumpCurrentCode),
        .chargePumpCurrentUa(chargePumpCurrentUa), .softResetBusy(softResetBusy));
    cgp_nv_store_model nv (.core_clk(core_clk), .arst_n(arst_n), .nvLoadReq(nvLoadReq),
        .nvLoadDone(nvLoadDone), .nvLoadData(nvLoadData));
    // Half period of the 100 ns clock.
    always #50 core_clk = ~core_clk;
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Each access holds its strobe over exactly one rising edge.
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(negedge core_clk);
        req.addr = a;
        req.wdata = d;
        req.wr = 1'b1;
        @(negedge core_clk);
        req.wr = 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        @(negedge core_clk);
        req.addr = a;
        req.rd = 1'b1;
        @(negedge core_clk);
        req.rd = 1'b0;
        chk(16'(rdValid), 16'h0001);
        chk(16'(rdata), 16'(e));
    endtask
    task automatic io();
        @(negedge core_clk);
        ioUpdate = 1'b1;
        @(negedge core_clk);
        ioUpdate = 1'b0;
        repeat (2) @(negedge core_clk);
    endtask
    task automatic waitIdle();
        int n;
        for (n = 0; n < 50 && softResetBusy !== 1'b0; n++) begin
            @(negedge core_clk);
        end
        // A reload that never ends counts here as a mismatch; the run goes on to the verdict.
        chk(16'(softResetBusy), 16'h0000);
    endtask
    initial begin
        logic [2:0] c;
        repeat (5) @(negedge core_clk);
        arst_n = 1'b1;
        rd(12'h000, 8'h00);
        rd(12'h004, 8'h00);
        rd(12'h005, 8'h00);
        rd(12'h006, 8'h00);
        rd(12'h010, 8'h7D);
        chk(16'(phaseDetectorSense), 16'h0000);
        chk(16'(chargePumpCurrentUa), 16'h12C0);
        $display("test reset done");
        rd(12'h003, 8'h5A);
        wr(12'h003, 8'hFF);
        rd(12'h003, 8'h5A);
        rd(12'h020, 8'h00);
        $display("test variant done");
        // Codes 0 to 4 of the eight, with the sense bit toggling on the way.
        for (int i = 0; i < 5; i++) begin
            c = 3'(i);
            wr(12'h010, {c[0], c, 4'hD});
            rd(12'h010, {c[0], c, 4'hD});
            // Until the update strobe the active bank still holds the previous code.
            chk(16'(chargePumpCurrentCode), (i == 0) ? 16'h0007 : 16'(i - 1));
            io();
            chk(16'(chargePumpCurrentCode), 16'(c));
            chk(16'(chargePumpCurrentUa), 16'((i + 1) * 600));
            chk(16'(phaseDetectorSense), 16'(c[0]));
        end
        $display("test pll done");
        wr(12'h010, 8'h05);
        rd(12'h010, 8'h05);
        wr(12'h004, 8'h01);
        rd(12'h010, 8'h4D);
        wr(12'h004, 8'h00);
        wr(12'h005, 8'h34);
        wr(12'h006, 8'h12);
        rd(12'h005, 8'h34);
        rd(12'h006, 8'h12);
        chk(16'(chargePumpCurrentCode), 16'h0004);
        $display("test readback done");
        i2cMode = 1'b1;
        wr(12'h000, 8'hC3);
        repeat (2) @(negedge core_clk);
        chk(16'(lsbFirst), 16'h0000);
        chk(16'(sdoActive), 16'h0000);
        i2cMode = 1'b0;
        repeat (2) @(negedge core_clk);
        chk(16'(lsbFirst), 16'h0001);
        chk(16'(sdoActive), 16'h0001);
        $display("test i2c done");
        wr(12'h000, 8'h24);
        waitIdle();
        rd(12'h000, 8'h00);
        rd(12'h005, 8'h00);
        rd(12'h010, 8'h7D);
        $display("test default reload done");
        nvSelectPin = 1'b1;
        repeat (6) @(negedge core_clk);
        wr(12'h000, 8'h24);
        chk(16'(nvLoadReq), 16'h0001);
        chk(16'(softResetBusy), 16'h0001);
        wr(12'h005, 8'hFF);
        waitIdle();
        rd(12'h000, 8'h00);
        rd(12'h005, 8'hA5);
        rd(12'h006, 8'h5A);
        rd(12'h010, 8'h25);
        @(negedge core_clk);
        chk(16'(chargePumpCurrentUa), 16'h0708);
        $display("test store reload done");
        print_verdict();
    end
endmodule
